// >>> sep_io_burst_pkg.sv
/*
  Shared constants and types for both ends of the separate-I/O burst SRAM link.
  Assumes a single 25 MHz reference clock on each end.
*/
package sep_io_burst_pkg;

  // ==========================================================
  // Data layout
  localparam int WORD_W     = 18;
  localparam int BURST_LEN  = 4;
  localparam int BURST_W    = WORD_W * BURST_LEN;
  localparam int LO_MSB     = 8;
  localparam int HI_LSB     = 9;

  // ==========================================================
  // Latency, counted in input clock edges (either polarity)
  localparam int LAT_LONG_EDGES  = 5;
  localparam int LAT_SHORT_EDGES = 2;
  localparam int RD_SLOTS        = 8;
  localparam int WR_FIRST_EDGE   = 2;
  localparam int WR_SLOTS        = 5;

  // ==========================================================
  // Timing
  localparam int REF_PERIOD_NS  = 40;
  localparam int REF_CLK_MHZ    = 25;
  localparam int K_HALF_CYC     = 4;
  localparam int K_MID          = 2;
  localparam int IMP_RECAL_CYC  = 1024;
  localparam int PLL_LOCK_US    = 20;
  localparam int PLL_LOCK_CYC   = PLL_LOCK_US * REF_CLK_MHZ;
  localparam int PLL_STOP_NS    = 30;
  localparam int PLL_STOP_CYC   = (PLL_STOP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int K_MIN_MHZ      = 120;

  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_type;

endpackage

// >>> sep_io_burst_if.sv
/*
  Pin-level link between the memory controller and the burst SRAM.
  Read data only has one driver, so no wire resolution is done here.
*/
`timescale 1ns/100ps
interface sep_io_burst_if #(parameter int ADDR_W = 20);
  logic                k;
  logic                k_n;
  logic                read_port_select_n;
  logic                write_port_select_n;
  logic [ADDR_W-1:0]   addr;
  logic [17:0]         d;
  logic [1:0]          byte_write_select_n;
  logic                pll_disable_n;
  logic                echo_timing_out;
  logic                echo_timing_out_n;
  logic [17:0]         q;
  logic                q_oe;
  logic                read_valid_flag;

  modport ctrl (
    output k, k_n, read_port_select_n, write_port_select_n, addr, d, byte_write_select_n, pll_disable_n,
    input  echo_timing_out, echo_timing_out_n, q, q_oe, read_valid_flag
  );
  modport sram (
    input  k, k_n, read_port_select_n, write_port_select_n, addr, d, byte_write_select_n, pll_disable_n,
    output echo_timing_out, echo_timing_out_n, q, q_oe, read_valid_flag
  );
endinterface

// >>> sep_io_burst_sram.sv
/*
  SRAM end: port selects, four-word DDR bursts, latency modes, arbitration,
  write-to-read forwarding, echo clocks, valid flag, lock and impedance timers.
  Assumes the link pins come from another clock domain; all are synchronised.
*/
`timescale 1ns/100ps
module sep_io_burst_sram
  import sep_io_burst_pkg::*;
#(
  parameter int ADDR_W = 20
)(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Link
  sep_io_burst_if.sram     link,
  // Status
  output logic             o_pll_locked,
  output logic             o_long_latency,
  output logic             o_impedance_recal
);

  typedef struct packed {
    logic              rps_n;
    logic              wps_n;
    logic [ADDR_W-1:0] addr;
    logic [17:0]       d;
    logic [1:0]        bws_n;
    logic              pll_n;
  } pin_in_type;

  localparam pin_in_type PIN_IDLE = '{rps_n: 1'b1, wps_n: 1'b1, addr: '0, d: '0, bws_n: 2'h3, pll_n: 1'b1};
  localparam int STOP_WIN = PLL_STOP_CYC + 2 * K_HALF_CYC;

  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old_w,
                                               input logic [WORD_W-1:0] new_w,
                                               input logic [1:0]        sel_n);
    logic [WORD_W-1:0] r;
    r = old_w;
    if (!sel_n[0])
    begin
      r[LO_MSB:0] = new_w[LO_MSB:0];
    end
    if (!sel_n[1])
    begin
      r[WORD_W-1:HI_LSB] = new_w[WORD_W-1:HI_LSB];
    end
    return r;
  endfunction

  // ==========================================================
  // Input synchronisers
  pin_in_type   in_s1, in_s2;
  logic [2:0]   k_sy, kn_sy;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      in_s1 <= PIN_IDLE;
      in_s2 <= PIN_IDLE;
      k_sy  <= 3'h0;
      // Complementary clock idles high, so no false edge after reset
      kn_sy <= 3'h7;
    end
    else
    begin
      in_s1 <= '{rps_n: link.read_port_select_n, wps_n: link.write_port_select_n, addr: link.addr,
                 d: link.d, bws_n: link.byte_write_select_n, pll_n: link.pll_disable_n};
      in_s2 <= in_s1;
      k_sy  <= {k_sy[1:0], link.k};
      kn_sy <= {kn_sy[1:0], link.k_n};
    end
  end

  logic k_rise, kn_rise, any_edge, pll_en;
  assign k_rise   = k_sy[1] & ~k_sy[2];
  assign kn_rise  = kn_sy[1] & ~kn_sy[2];
  assign any_edge = k_rise | kn_rise;
  assign pll_en   = in_s2.pll_n;

  // ==========================================================
  // Lock timer
  logic [7:0]  idle_cnt_r;
  logic [9:0]  lock_cnt_r;
  logic        locked_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      idle_cnt_r <= 8'h00;
      lock_cnt_r <= 10'h000;
      locked_r   <= 1'b0;
    end
    else
    begin
      if (k_rise)
        idle_cnt_r <= 8'h00;
      else if (idle_cnt_r != 8'(STOP_WIN))
        idle_cnt_r <= idle_cnt_r + 8'h01;
      // Stopped clock drops lock; counting restarts once edges return; loop off never locks
      if (idle_cnt_r == 8'(STOP_WIN) || !pll_en)
      begin
        lock_cnt_r <= 10'h000;
        locked_r   <= 1'b0;
      end
      else if (!locked_r)
      begin
        if (lock_cnt_r == 10'(PLL_LOCK_CYC - 1))
          locked_r <= 1'b1;
        else
          lock_cnt_r <= lock_cnt_r + 10'h001;
      end
    end
  end

  // ==========================================================
  // Arbitration
  op_type  last_op_r;
  logic    go, want_rd, want_wr, start_rd, start_wr;

  // Without the PLL there is nothing to wait for
  assign go       = ~pll_en | locked_r;
  assign want_rd  = go & ~in_s2.rps_n & (last_op_r != OP_READ);
  assign want_wr  = go & ~in_s2.wps_n & (last_op_r != OP_WRITE);
  assign start_rd = k_rise & want_rd;
  assign start_wr = k_rise & want_wr & ~want_rd;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      last_op_r <= OP_IDLE;
    else if (k_rise)
      last_op_r <= start_rd ? OP_READ : (start_wr ? OP_WRITE : OP_IDLE);
  end

  // ==========================================================
  // Burst slot pipelines, one entry per clock edge
  logic [RD_SLOTS-1:0]   rd_v_r;
  logic [ADDR_W-1:0]     rd_a_r [RD_SLOTS];
  logic [WR_SLOTS-1:0]   wr_v_r;
  logic [ADDR_W-1:0]     wr_a_r [WR_SLOTS];
  logic [2:0]            lat_m1;

  assign lat_m1 = pll_en ? 3'(LAT_LONG_EDGES - 1) : 3'(LAT_SHORT_EDGES - 1);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      rd_v_r <= '0;
      wr_v_r <= '0;
      for (int i = 0; i < RD_SLOTS; i++)
        rd_a_r[i] <= '0;
      for (int i = 0; i < WR_SLOTS; i++)
        wr_a_r[i] <= '0;
    end
    else if (any_edge)
    begin
      // Pending slots keep draining whatever the selects do
      for (int i = 0; i < RD_SLOTS - 1; i++)
      begin
        rd_v_r[i] <= rd_v_r[i+1];
        rd_a_r[i] <= rd_a_r[i+1];
      end
      rd_v_r[RD_SLOTS-1] <= 1'b0;
      for (int i = 0; i < WR_SLOTS - 1; i++)
      begin
        wr_v_r[i] <= wr_v_r[i+1];
        wr_a_r[i] <= wr_a_r[i+1];
      end
      wr_v_r[WR_SLOTS-1] <= 1'b0;
      if (start_rd)
      begin
        for (int i = 0; i < BURST_LEN; i++)
        begin
          rd_v_r[lat_m1 + 3'(i)] <= 1'b1;
          rd_a_r[lat_m1 + 3'(i)] <= ADDR_W'(in_s2.addr + ADDR_W'(i));
        end
      end
      if (start_wr)
      begin
        for (int i = 0; i < BURST_LEN; i++)
        begin
          wr_v_r[WR_FIRST_EDGE - 1 + i] <= 1'b1;
          wr_a_r[WR_FIRST_EDGE - 1 + i] <= ADDR_W'(in_s2.addr + ADDR_W'(i));
        end
      end
    end
  end

  // ==========================================================
  // Array
  logic [WORD_W-1:0] mem [0:(1 << ADDR_W) - 1];
  logic [WORD_W-1:0] rd_word;
  logic              commit;

  assign commit = any_edge & wr_v_r[0];

  always_ff @(posedge i_ref_clk)
  begin
    if (commit)
      mem[wr_a_r[0]] <= merge(mem[wr_a_r[0]], in_s2.d, in_s2.bws_n);
  end

  // Word landing on this very edge is forwarded
  always_comb
  begin
    if (commit && wr_a_r[0] == rd_a_r[0])
      rd_word = merge(mem[rd_a_r[0]], in_s2.d, in_s2.bws_n);
    else
      rd_word = mem[rd_a_r[0]];
  end

  // ==========================================================
  // Read outputs
  logic [17:0] q_r;
  logic        q_oe_r, valid_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      q_r     <= 18'h00000;
      q_oe_r  <= 1'b0;
      valid_r <= 1'b0;
    end
    else if (any_edge)
    begin
      valid_r <= rd_v_r[1];
      if (rd_v_r[0])
      begin
        q_r    <= rd_word;
        q_oe_r <= 1'b1;
      end
      else if (kn_rise)
        q_oe_r <= 1'b0;
    end
  end

  // ==========================================================
  // Echo clocks, recalibration, status
  logic        echo_r, echo_n_r, recal_r, long_lat_r;
  logic [9:0]  recal_cnt_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      echo_r      <= 1'b0;
      echo_n_r    <= 1'b0;
      recal_cnt_r <= 10'h000;
      recal_r     <= 1'b0;
      long_lat_r  <= 1'b1;
    end
    else
    begin
      echo_r     <= k_sy[1];
      echo_n_r   <= kn_sy[1];
      long_lat_r <= pll_en;
      recal_r    <= k_rise && recal_cnt_r == 10'(IMP_RECAL_CYC - 1);
      if (k_rise)
        recal_cnt_r <= recal_cnt_r + 10'h001;
    end
  end

  assign link.echo_timing_out   = echo_r;
  assign link.echo_timing_out_n = echo_n_r;
  assign link.q                 = q_r;
  assign link.q_oe              = q_oe_r;
  assign link.read_valid_flag   = valid_r;
  assign o_pll_locked           = locked_r;
  assign o_long_latency         = long_lat_r;
  assign o_impedance_recal      = recal_r;

endmodule

// >>> sep_io_burst_ctrl.sv
/*
  Controller end: makes the input clocks by division, issues one access per
  true clock cycle, streams write words and gathers returned read bursts.
  Assumes the user holds a request until the matching ready pulse.
*/
`timescale 1ns/100ps
module sep_io_burst_ctrl
  import sep_io_burst_pkg::*;
#(
  parameter int ADDR_W = 20
)(
  // Clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  // Link
  sep_io_burst_if.ctrl             link,
  // Configuration
  input  wire logic                i_pll_enable,
  input  wire logic                i_clk_hold,
  // Requests
  input  wire logic                i_rd_req,
  input  wire logic                i_wr_req,
  input  wire logic [ADDR_W-1:0]   i_addr,
  input  wire logic [BURST_W-1:0]  i_wr_data,
  input  wire logic [7:0]          i_wr_byte_en,
  output logic                     o_rd_ready,
  output logic                     o_wr_ready,
  // Read return
  output logic [BURST_W-1:0]       o_rd_data,
  output logic                     o_rd_data_valid
);

  // ==========================================================
  // Clock divider; the scaled rate stands in for the 120 MHz floor
  logic [2:0] ph_r;
  logic       k_r, kn_r, mid, pre_issue;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ph_r <= 3'h0;
      k_r  <= 1'b0;
      kn_r <= 1'b1;
    end
    else if (i_clk_hold)
    begin
      ph_r <= 3'h0;
      k_r  <= 1'b1;
      kn_r <= 1'b1;
    end
    else if (ph_r == 3'(K_HALF_CYC - 1))
    begin
      ph_r <= 3'h0;
      k_r  <= ~k_r;
      kn_r <= k_r;
    end
    else
    begin
      ph_r <= ph_r + 3'h1;
      // Restores the complement at once when a clock stop ends
      kn_r <= ~k_r;
    end
  end

  // Pins change mid-half so they are stable around each clock rise
  assign mid       = ~i_clk_hold & (ph_r == 3'(K_MID));
  assign pre_issue = ~i_clk_hold & ~k_r & (ph_r == 3'(K_MID - 1));

  // ==========================================================
  // Issue
  op_type             last_op_r;
  logic               rd_rdy_r, wr_rdy_r, take_rd, take_wr;
  logic               rps_n_r, wps_n_r;
  logic [ADDR_W-1:0]  addr_r;

  assign take_rd = rd_rdy_r & i_rd_req;
  assign take_wr = wr_rdy_r & i_wr_req & ~take_rd;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      rd_rdy_r  <= 1'b0;
      wr_rdy_r  <= 1'b0;
      rps_n_r   <= 1'b1;
      wps_n_r   <= 1'b1;
      addr_r    <= '0;
      last_op_r <= OP_IDLE;
    end
    else
    begin
      rd_rdy_r <= pre_issue && last_op_r != OP_READ;
      wr_rdy_r <= pre_issue && last_op_r != OP_WRITE;
      if (rd_rdy_r || wr_rdy_r)
      begin
        rps_n_r   <= ~take_rd;
        wps_n_r   <= ~take_wr;
        last_op_r <= take_rd ? OP_READ : (take_wr ? OP_WRITE : OP_IDLE);
        if (take_rd || take_wr)
          addr_r <= i_addr;
      end
    end
  end

  // ==========================================================
  // Write word pipeline, one entry per half cycle
  logic [WORD_W-1:0] wd_r [WR_SLOTS];
  logic [1:0]        wb_r [WR_SLOTS];
  logic [17:0]       d_r;
  logic [1:0]        bws_n_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      d_r     <= 18'h00000;
      bws_n_r <= 2'h3;
      for (int i = 0; i < WR_SLOTS; i++)
      begin
        wd_r[i] <= '0;
        wb_r[i] <= 2'h3;
      end
    end
    else if (mid)
    begin
      d_r     <= wd_r[0];
      bws_n_r <= wb_r[0];
      for (int i = 0; i < WR_SLOTS - 1; i++)
      begin
        wd_r[i] <= wd_r[i+1];
        wb_r[i] <= wb_r[i+1];
      end
      wd_r[WR_SLOTS-1] <= '0;
      wb_r[WR_SLOTS-1] <= 2'h3;
      if (take_wr)
      begin
        for (int i = 0; i < BURST_LEN; i++)
        begin
          wd_r[WR_FIRST_EDGE - 1 + i] <= i_wr_data[i*WORD_W +: WORD_W];
          wb_r[WR_FIRST_EDGE - 1 + i] <= ~i_wr_byte_en[2*i +: 2];
        end
      end
    end
  end

  // ==========================================================
  // Read capture on echo edges
  logic [2:0]        e_sy, en_sy;
  logic [1:0]        v_sy;
  logic [17:0]       q_s1, q_s2;
  logic              e_edge, v_prev_r, rd_val_r;
  logic [1:0]        rcnt_r;
  logic [BURST_W-1:0] rbuf_r, rd_data_r;

  assign e_edge = (e_sy[1] & ~e_sy[2]) | (en_sy[1] & ~en_sy[2]);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      e_sy      <= 3'h0;
      en_sy     <= 3'h0;
      v_sy      <= 2'h0;
      q_s1      <= 18'h00000;
      q_s2      <= 18'h00000;
      v_prev_r  <= 1'b0;
      rcnt_r    <= 2'h0;
      rbuf_r    <= '0;
      rd_data_r <= '0;
      rd_val_r  <= 1'b0;
    end
    else
    begin
      e_sy     <= {e_sy[1:0], link.echo_timing_out};
      en_sy    <= {en_sy[1:0], link.echo_timing_out_n};
      v_sy     <= {v_sy[0], link.read_valid_flag};
      q_s1     <= link.q;
      q_s2     <= q_s1;
      rd_val_r <= 1'b0;
      if (e_edge)
      begin
        // Flag leads data by one edge
        v_prev_r <= v_sy[1];
        if (v_prev_r)
        begin
          rbuf_r <= {q_s2, rbuf_r[BURST_W-1:WORD_W]};
          rcnt_r <= rcnt_r + 2'h1;
          if (rcnt_r == 2'(BURST_LEN - 1))
          begin
            rd_data_r <= {q_s2, rbuf_r[BURST_W-1:WORD_W]};
            rd_val_r  <= 1'b1;
          end
        end
      end
    end
  end

  assign link.k                   = k_r;
  assign link.k_n                 = kn_r;
  assign link.read_port_select_n  = rps_n_r;
  assign link.write_port_select_n = wps_n_r;
  assign link.addr                = addr_r;
  assign link.d                   = d_r;
  assign link.byte_write_select_n = bws_n_r;
  assign link.pll_disable_n       = i_pll_enable;
  assign o_rd_ready               = rd_rdy_r;
  assign o_wr_ready               = wr_rdy_r;
  assign o_rd_data                = rd_data_r;
  assign o_rd_data_valid          = rd_val_r;

endmodule

// >>> sep_io_burst_props.sv
/*
  Pin checker for the burst SRAM link, fed the interface signals directly.
  Assumes the controller's clock hold input is fed in; clock checks pause
  while it is high and for one cycle after.
*/
`timescale 1ns/100ps
module sep_io_burst_props
  import sep_io_burst_pkg::*;
#(
  parameter int ADDR_W = 20
)(
  // Clock and reset
  input wire logic              i_ref_clk,
  input wire logic              i_rst,
  input wire logic              i_clk_hold,
  // Controller side
  input wire logic              k,
  input wire logic              k_n,
  input wire logic              read_port_select_n,
  input wire logic              write_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [17:0]       d,
  input wire logic [1:0]        byte_write_select_n,
  input wire logic              pll_disable_n,
  // Device side
  input wire logic              echo_timing_out,
  input wire logic              echo_timing_out_n,
  input wire logic [17:0]       q,
  input wire logic              q_oe,
  input wire logic              read_valid_flag
);
  // Clock stop and the cycle after it leave both clocks high
  logic hold_d;

  always_ff @(posedge i_ref_clk)
  begin
    hold_d <= i_clk_hold;
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst || i_clk_hold || hold_d);

  // ==========================================================
  // Link clocks
  chk_k_compl: assert property (k_n == !k)
    else $error("k_n is not the inverse of k");
  chk_k_period: assert property ($rose(k) |-> k[*4] ##1 !k)
    else $error("k high phase is not four cycles");
  chk_echo_period: assert property ($rose(echo_timing_out) |-> ##4 !echo_timing_out)
    else $error("echo clock high phase wrong");

  // ==========================================================
  // Port selects
  chk_rd_spacing: assert property ($rose(k) && !read_port_select_n |-> ##8 read_port_select_n)
    else $error("read select on consecutive k rises");
  chk_wr_spacing: assert property ($rose(k) && !write_port_select_n |-> ##8 write_port_select_n)
    else $error("write select on consecutive k rises");

  // ==========================================================
  // Read outputs
  // Reset must be seen on its own edges, so the default disable is overridden
  chk_reset_idle: assert property (disable iff (1'b0) i_rst |=> !q_oe && !read_valid_flag && q == '0)
    else $error("read outputs not idle after reset");
  chk_valid_lead: assert property ($rose(read_valid_flag) |-> ##4 q_oe)
    else $error("first word not one edge after valid");
  chk_burst_len: assert property ($rose(read_valid_flag) |-> read_valid_flag[*8] ##8 read_valid_flag)
    else $error("valid shorter than four words");
  chk_oe_float: assert property ($fell(read_valid_flag) |-> q_oe[*4] ##[1:8] !q_oe)
    else $error("read outputs not released after burst");
  chk_q_echo: assert property ($changed(q) |-> $changed(echo_timing_out) || $changed(echo_timing_out_n))
    else $error("read word not aligned with echo clock");

  cov_read: cover property ($rose(read_valid_flag));
  cov_write: cover property ($rose(k) && !write_port_select_n);
  cov_float: cover property ($fell(q_oe));
endmodule

// >>> sep_io_burst_ports_test.sv
/*
  Self-checking bench: controller and SRAM ends joined by the link interface.
  Assumes one reference clock drives both ends.
*/
`timescale 1ns/100ps
module sep_io_burst_sram_ports_test;
  import sep_io_burst_pkg::*;
  localparam int AW    = 8;
  localparam int LIMIT = 40000;

  logic                 ref_clk = 1'b0;
  logic                 rst     = 1'b1;
  logic                 pll_en  = 1'b0;
  logic                 clk_hold = 1'b0;
  logic                 rd_req  = 1'b0;
  logic                 wr_req  = 1'b0;
  logic [AW-1:0]        addr    = '0;
  logic [BURST_W-1:0]   wr_data = '0;
  logic [7:0]           byte_en = '0;
  logic                 rd_ready, wr_ready, rd_valid, locked, long_lat, recal;
  logic [BURST_W-1:0]   rd_data;
  logic [WORD_W-1:0]    mem [0:(1<<AW)-1];
  logic [AW-1:0]        bases [4] = '{8'h00, 8'h40, 8'h7d, 8'hfe};
  logic [7:0]           be_tab [4] = '{8'h00, 8'h55, 8'haa, 8'h1e};
  int                   err_count  = 0;
  int                   n_compared = 0;
  int                   cycles     = 0;

  always #(REF_PERIOD_NS / 2) ref_clk = ~ref_clk;

  // ==========================================================
  // Design and checker
  sep_io_burst_if #(.ADDR_W(AW)) link_if ();
  sep_io_burst_sram #(.ADDR_W(AW)) i_sep_io_burst_sram (
    .i_ref_clk(ref_clk), .i_rst(rst), .link(link_if.sram),
    .o_pll_locked(locked), .o_long_latency(long_lat), .o_impedance_recal(recal));
  sep_io_burst_ctrl #(.ADDR_W(AW)) i_sep_io_burst_ctrl (
    .i_ref_clk(ref_clk), .i_rst(rst), .link(link_if.ctrl), .i_pll_enable(pll_en),
    .i_clk_hold(clk_hold), .i_rd_req(rd_req), .i_wr_req(wr_req), .i_addr(addr),
    .i_wr_data(wr_data), .i_wr_byte_en(byte_en), .o_rd_ready(rd_ready),
    .o_wr_ready(wr_ready), .o_rd_data(rd_data), .o_rd_data_valid(rd_valid));
  sep_io_burst_props #(.ADDR_W(AW)) i_sep_io_burst_props (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_clk_hold(clk_hold), .k(link_if.k), .k_n(link_if.k_n),
    .read_port_select_n(link_if.read_port_select_n), .write_port_select_n(link_if.write_port_select_n),
    .addr(link_if.addr), .d(link_if.d), .byte_write_select_n(link_if.byte_write_select_n),
    .pll_disable_n(link_if.pll_disable_n), .echo_timing_out(link_if.echo_timing_out),
    .echo_timing_out_n(link_if.echo_timing_out_n), .q(link_if.q), .q_oe(link_if.q_oe),
    .read_valid_flag(link_if.read_valid_flag));

  // ==========================================================
  // Compare and report
  task automatic cmp_data(input string what, input logic [BURST_W-1:0] exp, input logic [BURST_W-1:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s exp=%h got=%h", what, exp, got);
    end
  endtask

  task automatic cmp_flag(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s exp=%b got=%b", what, exp, got);
    end
  endtask

  task automatic cmp_count(input string what, input int exp, input int got);
    n_compared++;
    if (got != exp)
    begin
      err_count++;
      $display("[ERR] %s exp=%0d got=%0d", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("compared=%0d mismatches=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Expected memory image
  function automatic logic [BURST_W-1:0] exp_burst(input logic [AW-1:0] a);
    logic [BURST_W-1:0] r;
    for (int i = 0; i < BURST_LEN; i++)
      r[i*WORD_W +: WORD_W] = mem[AW'(a + i)];
    return r;
  endfunction

  // Address wraps at the top of the array, as the burst does
  function automatic void model_write(input logic [AW-1:0] a, input logic [BURST_W-1:0] v, input logic [7:0] be);
    for (int i = 0; i < BURST_LEN; i++)
    begin
      if (be[2*i])
        mem[AW'(a + i)][LO_MSB:0] = v[i*WORD_W +: HI_LSB];
      if (be[2*i+1])
        mem[AW'(a + i)][WORD_W-1:HI_LSB] = v[i*WORD_W+HI_LSB +: WORD_W-HI_LSB];
    end
  endfunction

  // ==========================================================
  // User-side requests, held until the ready pulse
  task automatic do_write(input logic [AW-1:0] a, input logic [BURST_W-1:0] v, input logic [7:0] be);
    int n;
    n = 0;
    @(posedge ref_clk);
    wr_req  <= 1'b1;
    addr    <= a;
    wr_data <= v;
    byte_en <= be;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (wr_ready !== 1'b1 && n < 100);
    wr_req <= 1'b0;
    cmp_flag("wr_ready", 1'b1, wr_ready);
    model_write(a, v, be);
  endtask

  task automatic do_read(input logic [AW-1:0] a);
    logic [BURST_W-1:0] exp;
    int n;
    exp = exp_burst(a);
    n = 0;
    @(posedge ref_clk);
    rd_req <= 1'b1;
    addr   <= a;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (rd_ready !== 1'b1 && n < 100);
    rd_req <= 1'b0;
    cmp_flag("rd_ready", 1'b1, rd_ready);
    n = 0;
    while (rd_valid !== 1'b1 && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    cmp_data("rd_data", exp, rd_data);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    int gap;
    void'($urandom(32'hb9569528));
    for (int m = 0; m < 2; m++)
    begin
      pll_en <= m[0];
      rst    <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      // Accesses are dropped until lock when the loop is on
      // Latency mode pin needs two sync stages and a status register
      repeat (m * (PLL_LOCK_CYC + 100) + 8) @(posedge ref_clk);
      cmp_flag("locked", m[0], locked);
      cmp_flag("long_latency", m[0], long_lat);
      for (int b = 0; b < 4; b++)
        do_write(bases[b], BURST_W'({$urandom, $urandom, $urandom}), 8'hff);
      for (int b = 0; b < 4; b++)
        do_read(bases[b]);
      for (int b = 0; b < 4; b++)
      begin
        do_write(bases[1], BURST_W'({$urandom, $urandom, $urandom}), be_tab[b]);
        do_read(bases[1]);
      end
      for (int j = 0; j < 16; j++)
      begin
        if ($urandom_range(1) == 1)
          do_write(bases[$urandom_range(3)], BURST_W'({$urandom, $urandom, $urandom}), 8'($urandom));
        else
          do_read(bases[$urandom_range(3)]);
      end
      // Stop both clocks high long enough to drop lock, then let it relock
      if (m == 1)
      begin
        repeat (40) @(posedge ref_clk);
        clk_hold <= 1'b1;
        repeat (24) @(posedge ref_clk);
        cmp_flag("locked_stopped", 1'b0, locked);
        clk_hold <= 1'b0;
        repeat (PLL_LOCK_CYC + 100) @(posedge ref_clk);
        cmp_flag("locked_again", 1'b1, locked);
        do_read(bases[2]);
      end
      $display("latency mode %0d done", m);
    end
    // Recalibration interval counted in reference cycles of a free-running k
    gap = 0;
    while (recal !== 1'b1 && gap < 9000)
    begin
      @(posedge ref_clk);
      gap++;
    end
    gap = 0;
    do
    begin
      @(posedge ref_clk);
      gap++;
    end while (recal !== 1'b1 && gap < 9000);
    cmp_count("recal_gap", IMP_RECAL_CYC * 2 * K_HALF_CYC, gap);
    $display("recalibration test done");
    report_and_stop();
  end
endmodule
